//--- udsr_partner.sv
// udsr_partner: remote serial end, sends frames in and decodes frames out
// assumes the bench clock, line idle high, lsb first, 8 data bits
`timescale 1ns/1ps
`default_nettype none

module udsr_partner #(
  parameter int unsigned BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic serial_tx,
  output logic serial_rx
);
  logic [7:0] got_byte;
  int got_cnt = 0;

  initial serial_rx = 1'h1;

  // one frame; stop level and a one-clock glitch chosen by the caller
  task automatic send(input logic [7:0] d, input logic par_en, input logic par,
      input logic stop, input int gl_bit);
    logic [10:0] fr;
    int nb;
    // low stop is a framing fault, all low a break
    fr = par_en ? {stop, par, d, 1'h0} : {1'h1, stop, d, 1'h0};
    nb = par_en ? 11 : 10;
    for (int k = 0; k < nb; k++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge clk);
        // glitch hits the middle vote, so only the filter can outvote it
        serial_rx <= (k == gl_bit && c == BIT_CLKS / 2 + 1) ? ~fr[k] : fr[k];
      end
    end
    @(posedge clk);
    serial_rx <= 1'h1;
    repeat (2 * BIT_CLKS) @(posedge clk);
  endtask

  // decode what the block sends; only frames with a high stop are counted
  initial begin
    forever begin
      @(negedge serial_tx);
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk);
        got_byte[i] = serial_tx;
      end
      repeat (BIT_CLKS) @(posedge clk);
      if (serial_tx) got_cnt++;
    end
  end
endmodule
`default_nettype wire

//--- udsr_pkg.sv
// udsr_pkg: shared constants and carrier types for the serial data/status block
// assumes a 32-bit axi4-lite register bus and one system clock
package udsr_pkg;

  // system clock rate and default line rate
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BAUD_DEFAULT = 115_200;
  localparam int unsigned BIT_CLKS_DEFAULT = CLK_HZ / BAUD_DEFAULT;

  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_DATA = 10'h0f1;
  localparam logic [9:0] IDX_FLAGS = 10'h0f2;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h0f8;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0f9;
  localparam logic [9:0] IDX_CTRL = 10'h0fa;

  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h02;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // control register field positions
  localparam int unsigned CTRL_PAR_EN = 0;
  localparam int unsigned CTRL_PAR_ODD = 1;
  localparam int unsigned CTRL_TWO_STOP = 2;

  // interrupt status / mask bit positions
  localparam int unsigned IRQ_RX_DATA = 0;
  localparam int unsigned IRQ_TX_READY = 1;
  localparam int unsigned IRQ_RX_ERR = 2;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // flags register layout, bit 7 first
  typedef struct packed {
    logic rx_full;
    logic par_err;
    logic ovr_err;
    logic frm_err;
    logic brk;
    logic tx_rdy;
    logic tx_cmpl;
    logic noise;
  } udsr_flags_t;

  // one finished receive character and its conditions
  typedef struct packed {
    logic [7:0] data;
    logic par_err;
    logic frm_err;
    logic brk;
    logic noise;
  } udsr_rx_res_t;

endpackage

//--- udsr_properties.sv
// udsr_properties: port-level timing and decode checks for udsr_top
// assumes one clock, rstn synchronous active low, bound by the statement below
`timescale 1ns/1ps
`default_nettype none

module udsr_properties #(
  parameter int unsigned BIT_CLKS = 16,
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_tx,
  input wire logic irq
);
  logic [15:0] low_run_r;
  logic ar_go, aw_go;
  logic [9:0] ar_idx, aw_idx;

  function automatic logic mapped(input logic [9:0] i);
    return i inside {udsr_pkg::IDX_DATA, udsr_pkg::IDX_FLAGS, udsr_pkg::IDX_IRQ_STAT,
      udsr_pkg::IDX_IRQ_MASK, udsr_pkg::IDX_CTRL};
  endfunction

  // handshakes and word indices
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign aw_go = s_axi_awvalid && s_axi_awready;
  assign ar_idx = s_axi_araddr[11:2];
  assign aw_idx = s_axi_awaddr[11:2];

  // length of the current low run on the line; bit cells must be whole
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_run_r <= 16'h0;
    end else if (!serial_tx) begin
      low_run_r <= low_run_r + 16'h1;
    end else begin
      low_run_r <= 16'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_rd_lat;
    ar_go |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer not released");
  property p_wr_lat;
    aw_go && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer timing wrong");
  property p_data_map;
    ar_go && ar_idx == udsr_pkg::IDX_DATA |=>
      s_axi_rresp == udsr_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_data_map: assert property (p_data_map) else $error("data byte decode wrong");
  property p_flags_map;
    ar_go && ar_idx == udsr_pkg::IDX_FLAGS |=>
      s_axi_rresp == udsr_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_flags_map: assert property (p_flags_map) else $error("flags decode wrong");
  property p_unmapped_rd;
    ar_go && !mapped(ar_idx) |=> s_axi_rresp == udsr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("stray read answered");
  property p_unmapped_wr;
    aw_go && s_axi_wvalid && s_axi_wready && !mapped(aw_idx) |->
      ##2 (s_axi_bvalid && s_axi_bresp == udsr_pkg::RESP_SLVERR);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("stray write answered");
  property p_tx_idle;
    disable iff (1'h0) !rstn |=> serial_tx && !irq;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("line or irq active in reset");
  property p_tx_bits;
    $rose(serial_tx) |-> (low_run_r % BIT_CLKS) == 0;
  endproperty
  a_tx_bits: assert property (p_tx_bits) else $error("transmit bit cell length wrong");
endmodule

bind udsr_top udsr_properties #(.BIT_CLKS(BIT_CLKS), .ADDR_W(ADDR_W)) u_props (.clk, .rstn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .serial_tx, .irq);
`default_nettype wire

//--- udsr_top.sv
// udsr_top: serial port data byte, flags byte, interrupt and frame logic
// assumes axi4-lite master on clk, serial_rx already synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module udsr_top #(
  parameter int unsigned BIT_CLKS = udsr_pkg::BIT_CLKS_DEFAULT,
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_rx,
  output logic serial_tx,
  output logic irq
);

  localparam logic [15:0] BIT_END = 16'(BIT_CLKS - 1);
  localparam logic [15:0] HALF = 16'(BIT_CLKS / 2);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRKWAIT} udsr_rx_st_t;

  // bus slave state
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rd_mux;
  logic [9:0] wr_idx, rd_idx;
  logic wstrb0_r, wr_go, rd_fire, rd_data, wr_data, wr_ok, rd_ok;
  // software-visible state
  logic [7:0] rx_data_r;
  udsr_pkg::udsr_flags_t flags;
  logic [3:0] err_r;
  logic rx_full_r, noise_r, filt_en_r, tx_rdy_r;
  logic [2:0] ctrl_r, irq_stat_r, irq_mask_r, irq_set, irq_clr;
  // receive path
  udsr_rx_st_t rx_st_r;
  logic [15:0] rx_cnt_r;
  logic [7:0] rx_sh_r;
  logic [2:0] samp_r, rx_idx_r;
  logic rx_par_r, rx_zero_r, rx_noisy_r, rx_par_err_r, rx_done_r, rx_bit, samp_odd;
  udsr_pkg::udsr_rx_res_t rx_res_r;
  // transmit path
  logic [7:0] tx_hold_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_bits_r;
  logic [15:0] tx_cnt_r;
  logic tx_hold_full_r, tx_busy_r, tx_first_r, tx_bit_end, tx_start_done;

  // address decode helpers
  assign wr_idx = awaddr_r[11:2];
  assign rd_idx = s_axi_araddr[11:2];
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_data = rd_fire && (rd_idx == udsr_pkg::IDX_DATA);
  assign wr_data = wr_go && wstrb0_r && (wr_idx == udsr_pkg::IDX_DATA);

  // write channel: address and data taken in either order, then answered
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= udsr_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? udsr_pkg::RESP_OKAY : udsr_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // writable decode; unmapped index answers slverr
  always_comb begin
    wr_ok = 1'b0;
    if (wr_idx == udsr_pkg::IDX_DATA || wr_idx == udsr_pkg::IDX_FLAGS) begin
      wr_ok = 1'b1;
    end else if (wr_idx == udsr_pkg::IDX_IRQ_STAT || wr_idx == udsr_pkg::IDX_IRQ_MASK ||
                 wr_idx == udsr_pkg::IDX_CTRL) begin
      wr_ok = 1'b1;
    end
  end

  // flags byte as software sees it
  always_comb begin
    flags.rx_full = rx_full_r;
    flags.par_err = err_r[3];
    flags.ovr_err = err_r[2];
    flags.frm_err = err_r[1];
    flags.brk = err_r[0];
    flags.tx_rdy = tx_rdy_r;
    flags.tx_cmpl = !tx_busy_r && !tx_hold_full_r;
    flags.noise = noise_r;
  end

  // read decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rd_idx == udsr_pkg::IDX_DATA) begin
      rd_mux[7:0] = rx_data_r;
    end else if (rd_idx == udsr_pkg::IDX_FLAGS) begin
      rd_mux[7:0] = flags;
    end else if (rd_idx == udsr_pkg::IDX_IRQ_STAT) begin
      rd_mux[2:0] = irq_stat_r;
    end else if (rd_idx == udsr_pkg::IDX_IRQ_MASK) begin
      rd_mux[2:0] = irq_mask_r;
    end else if (rd_idx == udsr_pkg::IDX_CTRL) begin
      rd_mux[2:0] = ctrl_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read channel: one outstanding read, data registered at the address handshake
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= udsr_pkg::RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? udsr_pkg::RESP_OKAY : udsr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // plain control registers: frame format, filter enable, interrupt mask
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= udsr_pkg::CTRL_RST;
      irq_mask_r <= udsr_pkg::IRQ_RST;
      filt_en_r <= 1'b0;
    end else if (wr_go && wstrb0_r) begin
      if (wr_idx == udsr_pkg::IDX_CTRL) begin
        ctrl_r <= wdata_r[2:0];
      end else if (wr_idx == udsr_pkg::IDX_IRQ_MASK) begin
        irq_mask_r <= wdata_r[2:0];
      end else if (wr_idx == udsr_pkg::IDX_FLAGS) begin
        filt_en_r <= wdata_r[0];
      end
    end
  end

  // three mid-bit samples; filter takes the majority, otherwise the middle one
  assign samp_odd = !(samp_r[0] == samp_r[1] && samp_r[1] == samp_r[2]);
  assign rx_bit = filt_en_r ? ((samp_r[0] & samp_r[1]) | (samp_r[1] & samp_r[2]) |
                  (samp_r[0] & samp_r[2])) : samp_r[1];

  // receive frame: start, 8 data lsb first, optional parity, first stop checked
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= 16'h0000;
      samp_r <= 3'h7;
      rx_sh_r <= 8'h00;
      rx_idx_r <= 3'h0;
      rx_par_r <= 1'b0;
      rx_zero_r <= 1'b0;
      rx_noisy_r <= 1'b0;
      rx_par_err_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_res_r <= '0;
    end else begin
      rx_done_r <= 1'b0;
      if (rx_st_r != RX_IDLE && rx_st_r != RX_BRKWAIT) begin
        rx_cnt_r <= (rx_cnt_r == BIT_END) ? 16'h0000 : rx_cnt_r + 16'h0001;
        if (rx_cnt_r == HALF - 16'h0001) samp_r[0] <= serial_rx;
        if (rx_cnt_r == HALF) samp_r[1] <= serial_rx;
        if (rx_cnt_r == HALF + 16'h0001) samp_r[2] <= serial_rx;
      end
      case (rx_st_r)
        RX_IDLE: begin
          if (!serial_rx) begin
            rx_st_r <= RX_START;
            rx_cnt_r <= 16'h0000;
            rx_idx_r <= 3'h0;
            rx_par_r <= ctrl_r[udsr_pkg::CTRL_PAR_ODD];
            rx_zero_r <= 1'b1;
            rx_noisy_r <= 1'b0;
            rx_par_err_r <= 1'b0;
          end
        end
        RX_START: begin
          if (rx_cnt_r == BIT_END) begin
            // a start bit that votes high was a glitch
            rx_st_r <= rx_bit ? RX_IDLE : RX_DATA;
            rx_noisy_r <= samp_odd;
          end
        end
        RX_DATA: begin
          if (rx_cnt_r == BIT_END) begin
            rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
            rx_par_r <= rx_par_r ^ rx_bit;
            rx_zero_r <= rx_zero_r & !rx_bit;
            rx_noisy_r <= rx_noisy_r | samp_odd;
            rx_idx_r <= rx_idx_r + 3'h1;
            if (rx_idx_r == 3'h7) begin
              rx_st_r <= ctrl_r[udsr_pkg::CTRL_PAR_EN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_cnt_r == BIT_END) begin
            // running xor seeded with the odd select must end at zero
            rx_par_err_r <= rx_par_r ^ rx_bit;
            rx_zero_r <= rx_zero_r & !rx_bit;
            rx_noisy_r <= rx_noisy_r | samp_odd;
            rx_st_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          // finish just after the third sample so a back-to-back start is not missed
          if (rx_cnt_r == HALF + 16'h0002) begin
            rx_done_r <= 1'b1;
            rx_res_r.data <= rx_sh_r;
            rx_res_r.par_err <= rx_par_err_r;
            rx_res_r.frm_err <= !rx_bit;
            rx_res_r.brk <= rx_zero_r & !rx_bit;
            rx_res_r.noise <= rx_noisy_r | samp_odd;
            rx_st_r <= (rx_zero_r & !rx_bit) ? RX_BRKWAIT : RX_IDLE;
          end
        end
        RX_BRKWAIT: begin
          // a held-low line would otherwise restart a frame every character time
          if (serial_rx) rx_st_r <= RX_IDLE;
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // receive holding byte and its flags; a new event wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_data_r <= 8'h00;
      rx_full_r <= 1'b0;
      err_r <= 4'h0;
      noise_r <= 1'b0;
    end else begin
      if (rx_done_r && !rx_full_r) begin
        rx_data_r <= rx_res_r.data;
        noise_r <= rx_res_r.noise;
        rx_full_r <= 1'b1;
      end else if (rd_data) begin
        rx_full_r <= 1'b0;
      end
      // overrun keeps the unread byte; the flags and the rx error interrupt status record the loss
      err_r <= (rd_data ? 4'h0 : err_r) |
               (rx_done_r ? {rx_res_r.par_err, rx_full_r, rx_res_r.frm_err, rx_res_r.brk} :
               4'h0);
    end
  end

  assign tx_bit_end = tx_busy_r && (tx_cnt_r == BIT_END);
  assign tx_start_done = tx_bit_end && tx_first_r;

  // transmit holding byte and shifter; holding stays taken until start bit is out
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_hold_r <= 8'h00;
      tx_hold_full_r <= 1'b0;
      tx_busy_r <= 1'b0;
      tx_first_r <= 1'b0;
      tx_sh_r <= 11'h7ff;
      tx_bits_r <= 4'h0;
      tx_cnt_r <= 16'h0000;
      tx_rdy_r <= udsr_pkg::FLAGS_RST[2];
      serial_tx <= 1'b1;
    end else begin
      if (!tx_busy_r && tx_hold_full_r) begin
        tx_busy_r <= 1'b1;
        tx_first_r <= 1'b1;
        tx_cnt_r <= 16'h0000;
        serial_tx <= 1'b0;
        tx_sh_r[7:0] <= tx_hold_r;
        tx_sh_r[8] <= ctrl_r[udsr_pkg::CTRL_PAR_EN] ?
                      (^tx_hold_r) ^ ctrl_r[udsr_pkg::CTRL_PAR_ODD] : 1'b1;
        tx_sh_r[10:9] <= 2'b11;
        tx_bits_r <= 4'h9 + {3'h0, ctrl_r[udsr_pkg::CTRL_PAR_EN]} +
                     {3'h0, ctrl_r[udsr_pkg::CTRL_TWO_STOP]};
      end else if (tx_busy_r) begin
        tx_cnt_r <= (tx_cnt_r == BIT_END) ? 16'h0000 : tx_cnt_r + 16'h0001;
        if (tx_bit_end) begin
          tx_first_r <= 1'b0;
          if (tx_bits_r == 4'h0) begin
            tx_busy_r <= 1'b0;
            serial_tx <= 1'b1;
          end else begin
            serial_tx <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_bits_r <= tx_bits_r - 4'h1;
          end
        end
      end
      if (tx_start_done) tx_hold_full_r <= 1'b0;
      // a write while not ready overwrites the waiting byte
      if (wr_data) begin
        tx_hold_r <= wdata_r[7:0];
        tx_hold_full_r <= 1'b1;
        tx_rdy_r <= 1'b0;
      end else if (tx_start_done) begin
        tx_rdy_r <= 1'b1;
      end else begin
        tx_rdy_r <= !tx_hold_full_r;
      end
    end
  end

  // interrupt events; set wins over a clear in the same cycle
  always_comb begin
    irq_set = 3'h0;
    irq_set[udsr_pkg::IRQ_RX_DATA] = rx_done_r && !rx_full_r;
    irq_set[udsr_pkg::IRQ_TX_READY] = tx_start_done;
    irq_set[udsr_pkg::IRQ_RX_ERR] = rx_done_r && (rx_full_r || rx_res_r.par_err ||
                                    rx_res_r.frm_err || rx_res_r.brk);
    irq_clr = 3'h0;
    if (wr_go && wstrb0_r && wr_idx == udsr_pkg::IDX_IRQ_STAT) begin
      irq_clr = wdata_r[2:0];
    end
    if (rd_data || wr_data) irq_clr[udsr_pkg::IRQ_RX_DATA] = 1'b1;
    if (wr_data) irq_clr[udsr_pkg::IRQ_TX_READY] = 1'b1;
  end

  // sticky status and one level interrupt output, one cycle behind status
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_stat_r <= udsr_pkg::IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

`default_nettype wire

//--- udsr_top_tb.sv
// udsr_top_tb: self-checking bench for the serial data and flags block
// assumes udsr_partner as far serial end and the bound port checker
`timescale 1ns/1ps
`default_nettype none

module udsr_top_tb;
  localparam int unsigned BC = 16;
  localparam logic [1:0] OK = udsr_pkg::RESP_OKAY;
  localparam logic [1:0] SE = udsr_pkg::RESP_SLVERR;
  localparam logic [9:0] D = udsr_pkg::IDX_DATA;
  localparam logic [9:0] F = udsr_pkg::IDX_FLAGS;
  localparam logic [9:0] IS = udsr_pkg::IDX_IRQ_STAT;
  localparam logic [9:0] M = udsr_pkg::IDX_IRQ_MASK;
  localparam logic [9:0] C = udsr_pkg::IDX_CTRL;
  logic clk = 1'h0;
  logic rstn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic serial_rx, serial_tx, irq;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0;
  int samples_checked = 0;

  always #10 clk = ~clk;

  udsr_top #(.BIT_CLKS(BC), .ADDR_W(12)) uut (.clk, .rstn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_rx,
    .serial_tx, .irq);
  udsr_partner #(.BIT_CLKS(BC)) u_far (.clk, .serial_tx, .serial_rx);

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] resp_exp);
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, resp_exp});
  endtask

  // one read; masked data and response compared
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] resp_exp,
      input logic [31:0] msk = 32'hffff_ffff);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    check($sformatf("rdata %h", idx), s_axi_rdata & msk, exp);
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, resp_exp});
  endtask

  // reset flags, stray places refused, receive interrupt unmasked
  task automatic t_reset();
    rd(F, 32'h06, OK);
    rd(10'h0f0, 32'h0, SE);
    wr(10'h0f3, 8'hff, SE);
    wr(M, 8'h01, OK);
    check("irq", {31'h0, irq}, 32'h0);
  endtask

  // clean byte: held, raises irq, both cleared by the data read
  task automatic t_rx();
    u_far.send(8'ha5, 1'h0, 1'h0, 1'h1, -1);
    rd(F, 32'h86, OK);
    check("irq", {31'h0, irq}, 32'h1);
    rd(D, 32'ha5, OK);
    idle(3);
    check("irq", {31'h0, irq}, 32'h0);
    rd(F, 32'h06, OK);
  endtask

  // write while a byte waits: rx irq drops, tx flags walk through the frame
  task automatic t_tx();
    u_far.send(8'h3c, 1'h0, 1'h0, 1'h1, -1);
    wr(D, 8'hc3, OK);
    idle(2);
    check("irq", {31'h0, irq}, 32'h0);
    rd(F, 32'h80, OK);
    idle(2 * BC); // no second byte while tx ready reads zero
    rd(F, 32'h84, OK);
    rd(IS, 32'h02, OK);
    for (int i = 0; i < 400 && u_far.got_cnt == 0; i++) @(posedge clk);
    idle(BC);
    check("tx byte", {24'h0, u_far.got_byte}, 32'hc3);
    rd(F, 32'h86, OK);
    rd(D, 32'h3c, OK);
    wr(IS, 8'h07, OK);
  endtask

  // parity, framing with two stops, break; each cleared by the data read
  task automatic t_err();
    wr(C, 8'h01, OK);
    wr(M, 8'h04, OK);
    u_far.send(8'h01, 1'h1, 1'h0, 1'h1, -1);
    rd(F, 32'hc6, OK);
    check("irq", {31'h0, irq}, 32'h1);
    wr(IS, 8'h04, OK);
    idle(2);
    check("irq", {31'h0, irq}, 32'h0);
    rd(D, 32'h01, OK);
    rd(F, 32'h06, OK);
    wr(C, 8'h04, OK);
    u_far.send(8'h55, 1'h0, 1'h0, 1'h0, -1);
    rd(F, 32'h96, OK);
    rd(D, 32'h55, OK);
    rd(F, 32'h06, OK);
    u_far.send(8'h00, 1'h0, 1'h0, 1'h0, -1);
    rd(F, 32'h9e, OK);
    rd(D, 32'h00, OK);
    rd(F, 32'h06, OK);
    wr(C, 8'h00, OK);
    wr(IS, 8'h07, OK);
  endtask

  // second byte before the read: first kept, overrun flagged
  task automatic t_ovr();
    u_far.send(8'h11, 1'h0, 1'h0, 1'h1, -1);
    u_far.send(8'h22, 1'h0, 1'h0, 1'h1, -1);
    rd(F, 32'ha6, OK);
    rd(D, 32'h11, OK);
    rd(F, 32'h06, OK);
  endtask

  // filter on: a single glitched sample is outvoted yet reported
  task automatic t_noise();
    wr(F, 8'h01, OK);
    u_far.send(8'h5a, 1'h0, 1'h0, 1'h1, 2);
    rd(F, 32'h87, OK);
    rd(D, 32'h5a, OK);
  endtask

  // reset held ten cycles, then the scenarios in turn
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    idle(2);
    t_reset();
    t_rx();
    t_tx();
    t_err();
    t_ovr();
    t_noise();
    wrap_up();
  end

  // hang guard, several times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
